// >>> hw/rmp_mac.sv
/*
 * MAC end of the reduced MII data port. User di-bits in the system clock
 * domain cross by toggle handshake to the link domain and are framed on
 * transmit enable; received di-bits cross back as toggle events.
 * Assumes the link clock is made outside and the user keeps up with the
 * line rate; at 100 Mb/s the handshake cannot, and frames end early.
 */
`timescale 1ns/1ps
`default_nettype none
module rmp_mac #(
	parameter int unsigned REP = rmp_pkg::REP_10M
) (
	// System clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Reduced MII link
	rmp_if.mac link,
	// Mode
	input wire logic i_speed100,
	// User transmit
	input wire logic i_tx_valid,
	input wire logic [rmp_pkg::DIBIT_W-1:0] i_tx_dibit,
	input wire logic i_tx_last,
	output logic o_tx_ready,
	// User receive and status
	output logic o_rx_valid,
	output logic [rmp_pkg::DIBIT_W-1:0] o_rx_dibit,
	output logic o_rx_err,
	output logic o_crs,
	output logic o_col
);
	import rmp_pkg::*;

	localparam logic [PHASE_W-1:0] PH_LAST = PHASE_W'(REP - 1);

	if (REP < 2 || REP >= (1 << PHASE_W)) begin : g_chk
		$error("rmp_mac: REP out of range");
	end

	logic rst_m;
	logic rst_r;
	logic tx_req;
	logic [DIBIT_W:0] tx_hold;
	logic ack_s;
	logic r_req_s;
	logic r_speed;
	logic seen;
	logic slot_full;
	logic [DIBIT_W:0] slot;
	logic tx_en;
	logic [DIBIT_W-1:0] txd;
	logic tx_last;
	logic [PHASE_W-1:0] tph;
	logic ttick;
	logic tload;
	logic [PHASE_W-1:0] rph;
	logic rtick;
	rmp_st_e rst_st;
	logic deliver;
	logic err_acc;
	logic rx_req;
	logic [DIBIT_W:0] rx_slot;
	logic col;
	logic m_req_s;
	logic m_req_q;
	logic m_crs;
	logic m_col;

	always_ff @(posedge i_mclk) begin
		rst_m <= i_rst;
	end

	// Crossings into the link domain and back
	rmp_sync #(.W(1)) u_rst (.i_clk(link.ref_clk), .i_rst(1'b0), .i_d(rst_m), .o_q(rst_r));
	rmp_sync #(.W(2)) u_tor (.i_clk(link.ref_clk), .i_rst(rst_r), .i_d({tx_req, i_speed100}),
		.o_q({r_req_s, r_speed}));
	rmp_sync #(.W(1)) u_ack (.i_clk(i_mclk), .i_rst(i_rst), .i_d(seen), .o_q(ack_s));
	rmp_sync #(.W(3)) u_tom (.i_clk(i_mclk), .i_rst(i_rst), .i_d({rx_req, link.crs_dv, col}),
		.o_q({m_req_s, m_crs, m_col}));

	// User transmit handshake: hold the di-bit until the link acknowledges
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			tx_req <= FLAG_RST;
			tx_hold <= '0;
			o_tx_ready <= FLAG_RST;
		end else begin
			if (i_tx_valid && o_tx_ready) begin
				tx_req <= ~tx_req;
				tx_hold <= {i_tx_last, i_tx_dibit};
			end
			o_tx_ready <= !(i_tx_valid && o_tx_ready) && ack_s == tx_req;
		end
	end

	// Transmit phase: starts on the tick that loads a di-bit, so the next
	// tick comes a full repeat later instead of on the following clock
	always_ff @(posedge link.ref_clk) begin
		if (rst_r || tph == PH_LAST) begin
			tph <= PHASE_RST;
		end else if (tload || tph != PHASE_RST) begin
			tph <= tph + 1'b1;
		end
	end

	assign ttick = r_speed || tph == PHASE_RST;
	assign tload = ttick && slot_full && !(tx_en && tx_last);

	// One-word slot: loaded from the handshake, emptied on a tick
	always_ff @(posedge link.ref_clk) begin
		if (rst_r) begin
			seen <= FLAG_RST;
			slot_full <= FLAG_RST;
			slot <= '0;
		end else if (slot_full) begin
			if (ttick && !(tx_en && tx_last)) begin
				slot_full <= 1'b0;
			end
		end else if (r_req_s != seen) begin
			seen <= r_req_s;
			slot <= tx_hold;
			slot_full <= 1'b1;
		end
	end

	// Frame the di-bits; enable drops at the tick after the last one
	always_ff @(posedge link.ref_clk) begin
		if (rst_r) begin
			tx_en <= FLAG_RST;
			txd <= IDLE_DIBIT;
			tx_last <= FLAG_RST;
		end else if (ttick) begin
			if (slot_full && !(tx_en && tx_last)) begin
				tx_en <= 1'b1;
				txd <= slot[DIBIT_W-1:0];
				tx_last <= slot[DIBIT_W];
			end else begin
				tx_en <= 1'b0;
				txd <= IDLE_DIBIT;
				tx_last <= 1'b0;
			end
		end
	end

	assign link.tx_en = tx_en;
	assign link.txd = txd;
	assign link.txd_hi = 2'h0;
	assign link.tx_er = 1'b0;

	// Receive phase restarts at each carrier rise
	always_ff @(posedge link.ref_clk) begin
		if (rst_r || !link.crs_dv || rph == PH_LAST) begin
			rph <= PHASE_RST;
		end else begin
			rph <= rph + 1'b1;
		end
	end

	assign rtick = link.crs_dv && (r_speed || rph == PHASE_RST);
	assign deliver = rtick && (rst_st == ST_DATA || (rst_st == ST_WAIT && link.rxd != IDLE_DIBIT));

	// Skip the 00 di-bits before decoding, then deliver every sample
	always_ff @(posedge link.ref_clk) begin
		if (rst_r) begin
			rst_st <= ST_IDLE;
		end else begin
			case (rst_st)
				ST_IDLE: rst_st <= link.crs_dv ? ST_WAIT : ST_IDLE;
				ST_WAIT: rst_st <= !link.crs_dv ? ST_IDLE : (deliver ? ST_DATA : ST_WAIT);
				ST_DATA: rst_st <= link.crs_dv ? ST_DATA : ST_IDLE;
				default: rst_st <= ST_IDLE;
			endcase
		end
	end

	// Collect errors between samples; a new error beats the clear
	always_ff @(posedge link.ref_clk) begin
		if (rst_r) begin
			err_acc <= FLAG_RST;
			rx_req <= FLAG_RST;
			rx_slot <= '0;
		end else begin
			err_acc <= (deliver ? 1'b0 : err_acc) | (link.rx_er && link.crs_dv);
			if (deliver) begin
				rx_req <= ~rx_req;
				rx_slot <= {err_acc | link.rx_er, link.rxd};
			end
		end
	end

	// Collision is transmit enable while carrier is up
	always_ff @(posedge link.ref_clk) begin
		if (rst_r) begin
			col <= FLAG_RST;
		end else begin
			col <= tx_en && link.crs_dv;
		end
	end

	// Receive event and status into the system domain
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			m_req_q <= FLAG_RST;
			o_rx_valid <= FLAG_RST;
			o_rx_dibit <= IDLE_DIBIT;
			o_rx_err <= FLAG_RST;
			o_crs <= FLAG_RST;
			o_col <= FLAG_RST;
		end else begin
			m_req_q <= m_req_s;
			o_rx_valid <= m_req_s ^ m_req_q;
			if (m_req_s ^ m_req_q) begin
				o_rx_dibit <= rx_slot[DIBIT_W-1:0];
				o_rx_err <= rx_slot[DIBIT_W];
			end
			o_crs <= m_crs;
			o_col <= m_col;
		end
	end
endmodule
`default_nettype wire

// >>> hw/rmp_pkg.sv
/*
 * Shared constants and types for the reduced MII data port: di-bit width,
 * idle code, 10 Mb/s repeat count, phase counter layout and state codes.
 * Assumes both ends import it; the interface does not; no clock or reset here.
 */
`default_nettype none
package rmp_pkg;
	localparam int unsigned DIBIT_W = 2;
	localparam logic [1:0] IDLE_DIBIT = 2'h0;
	localparam int unsigned REF_CLK_MHZ = 50;
	localparam int unsigned REP_10M = 10;
	localparam int unsigned PHASE_W = 4;
	localparam logic [3:0] PHASE_RST = 4'h0;
	localparam logic FLAG_RST = 1'h0;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_DATA = 3'b100
	} rmp_st_e;
endpackage
`default_nettype wire

// >>> hw/rmp_if.sv
/*
 * Reduced MII link between the PHY end and the MAC end.
 * Assumes the bench drives ref_clk; the upper data and error wires
 * exist only so the MAC end can hold them at ground.
 */
`timescale 1ns/1ps
`default_nettype none
interface rmp_if (
	input wire logic ref_clk
);
	logic crs_dv;
	logic [1:0] rxd;
	logic rx_er;
	logic tx_en;
	logic [1:0] txd;
	logic [1:0] txd_hi;
	logic tx_er;

	// PHY end: drives receive side, takes transmit side
	modport phy (
		input ref_clk,
		input tx_en,
		input txd,
		input txd_hi,
		input tx_er,
		output crs_dv,
		output rxd,
		output rx_er
	);

	// MAC end: drives transmit side, takes receive side
	modport mac (
		input ref_clk,
		input crs_dv,
		input rxd,
		input rx_er,
		output tx_en,
		output txd,
		output txd_hi,
		output tx_er
	);
endinterface
`default_nettype wire

// >>> hw/rmp_sync.sv
/*
 * Two-flop synchroniser for levels and toggles entering a clock domain.
 * Assumes each bit is independent or held stable around its toggle.
 */
`timescale 1ns/1ps
`default_nettype none
module rmp_sync #(
	parameter int unsigned W = 1
) (
	// Destination clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Data
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] meta;

	// First stage feeds only the second
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			meta <= '0;
			o_q <= '0;
		end else begin
			meta <= i_d;
			o_q <= meta;
		end
	end
endmodule
`default_nettype wire

// >>> hw/rmp_phy.sv
/*
 * PHY end of the reduced MII data port. Receive di-bits recovered by the
 * line logic go out on carrier/valid and receive data; transmit di-bits
 * from the MAC are handed to the line logic.
 * Assumes line-side inputs are asynchronous: a di-bit is stable before
 * its toggle flips and until the next flip, and the line paces di-bits
 * at the line rate. The link logic runs on the link reference clock.
 */
`timescale 1ns/1ps
`default_nettype none
module rmp_phy #(
	parameter int unsigned REP = rmp_pkg::REP_10M
) (
	// System clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Reduced MII link
	rmp_if.phy link,
	// Line receive side
	input wire logic i_speed100,
	input wire logic i_carrier,
	input wire logic i_rx_tgl,
	input wire logic [rmp_pkg::DIBIT_W-1:0] i_rx_dibit,
	input wire logic i_code_err,
	// Line transmit side
	output logic o_tx_en,
	output logic [rmp_pkg::DIBIT_W-1:0] o_tx_dibit,
	output logic o_tx_stb
);
	import rmp_pkg::*;

	localparam logic [PHASE_W-1:0] PH_LAST = PHASE_W'(REP - 1);

	// Refuse repeat counts the phase counter cannot hold
	if (REP < 2 || REP >= (1 << PHASE_W)) begin : g_chk
		$error("rmp_phy: REP out of range");
	end

	logic rst_m;
	logic rst_r;
	logic s_speed;
	logic s_car;
	logic s_tgl;
	logic s_err;
	logic [DIBIT_W-1:0] s_dib;
	logic tgl_q;
	logic rx_new;
	rmp_st_e state;
	logic crs_dv;
	logic [DIBIT_W-1:0] rxd;
	logic rx_er;
	logic [PHASE_W-1:0] phase;
	logic tx_tick;

	// Register reset in its own domain before carrying it across
	always_ff @(posedge i_mclk) begin
		rst_m <= i_rst;
	end

	// Reset into the link domain
	rmp_sync #(
		.W(1)
	) u_rst (
		.i_clk(link.ref_clk),
		.i_rst(1'b0),
		.i_d(rst_m),
		.o_q(rst_r)
	);

	// Line-side pins into the link domain
	rmp_sync #(
		.W(4 + DIBIT_W)
	) u_line (
		.i_clk(link.ref_clk),
		.i_rst(rst_r),
		.i_d({i_speed100, i_carrier, i_rx_tgl, i_code_err, i_rx_dibit}),
		.o_q({s_speed, s_car, s_tgl, s_err, s_dib})
	);

	// Toggle history for recovered di-bit events
	always_ff @(posedge link.ref_clk) begin
		if (rst_r) begin
			tgl_q <= FLAG_RST;
		end else begin
			tgl_q <= s_tgl;
		end
	end

	assign rx_new = s_tgl ^ tgl_q;

	// Carrier tracking: up on detection, down on the clock after loss
	always_ff @(posedge link.ref_clk) begin
		if (rst_r) begin
			state <= ST_IDLE;
			crs_dv <= FLAG_RST;
		end else begin
			case (state)
				ST_IDLE: begin
					if (s_car) begin
						state <= ST_WAIT;
						crs_dv <= 1'b1;
					end
				end
				ST_WAIT: begin
					if (!s_car) begin
						state <= ST_IDLE;
						crs_dv <= 1'b0;
					end else if (rx_new) begin
						state <= ST_DATA;
					end
				end
				ST_DATA: begin
					if (!s_car) begin
						state <= ST_IDLE;
						crs_dv <= 1'b0;
					end
				end
				default: begin
					state <= ST_IDLE;
					crs_dv <= 1'b0;
				end
			endcase
		end
	end

	// Receive data: idle and pre-decode show 00, then recovered di-bits
	always_ff @(posedge link.ref_clk) begin
		if (rst_r) begin
			rxd <= IDLE_DIBIT;
		end else if (!s_car || state == ST_IDLE) begin
			rxd <= IDLE_DIBIT;
		end else if (rx_new) begin
			rxd <= s_dib;
		end else if (state == ST_WAIT) begin
			rxd <= IDLE_DIBIT;
		end
	end

	// Receive error follows the line error only inside a frame
	always_ff @(posedge link.ref_clk) begin
		if (rst_r) begin
			rx_er <= FLAG_RST;
		end else begin
			rx_er <= s_err && s_car && state != ST_IDLE;
		end
	end

	// Link outputs come straight from the registers above
	assign link.crs_dv = crs_dv;
	assign link.rxd = rxd;
	assign link.rx_er = rx_er;

	// Transmit phase: one sample per REP clocks at 10 Mb/s
	always_ff @(posedge link.ref_clk) begin
		if (rst_r || !link.tx_en) begin
			phase <= PHASE_RST;
		end else if (phase == PH_LAST) begin
			phase <= PHASE_RST;
		end else begin
			phase <= phase + 1'b1;
		end
	end

	// Take a di-bit every clock at 100 Mb/s, on phase zero at 10 Mb/s
	assign tx_tick = link.tx_en && (s_speed || phase == PHASE_RST);

	// Hand transmit di-bits to the line; sampled on the rising edge
	always_ff @(posedge link.ref_clk) begin
		if (rst_r) begin
			o_tx_en <= FLAG_RST;
			o_tx_dibit <= IDLE_DIBIT;
			o_tx_stb <= FLAG_RST;
		end else begin
			o_tx_en <= link.tx_en;
			o_tx_stb <= tx_tick;
			if (!link.tx_en) begin
				o_tx_dibit <= IDLE_DIBIT;
			end else if (tx_tick) begin
				o_tx_dibit <= link.txd;
			end
		end
	end

	// No collision or self-test pulse exists after a frame here
	// the line side has no collision output at all
endmodule
`default_nettype wire

// >>> bench/rmp_monitor.sv
/*
 * Checker on the reduced MII link wires between the two ends.
 * Assumes the bench places it beside the link and feeds it the reset.
 */
`timescale 1ns/1ps
`default_nettype none
module rmp_monitor #(
	parameter int unsigned REP = 10
) (
	// Link clock and reset
	input wire logic ref_clk,
	input wire logic i_rst,
	// Link wires
	input wire logic crs_dv,
	input wire logic [1:0] rxd,
	input wire logic rx_er,
	input wire logic tx_en,
	input wire logic [1:0] txd,
	input wire logic [1:0] txd_hi,
	input wire logic tx_er
);
	logic [3:0] cnt;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (i_rst);
	// Slot position inside a held di-bit
	always_ff @(posedge ref_clk) begin
		if (!tx_en || cnt == 4'(REP - 1)) begin
			cnt <= 4'h0;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
	idle_rxd_a: assert property (!crs_dv |-> rxd == 2'h0) else $error("rxd not idle");
	idle_txd_a: assert property (!tx_en |-> txd == 2'h0) else $error("txd not idle");
	tie_low_a: assert property (txd_hi == 2'h0 && !tx_er) else $error("upper tx wires high");
	err_frame_a: assert property (rx_er |-> crs_dv) else $error("rx error outside frame");
	crs_first_a: assert property ($rose(crs_dv) |-> rxd == 2'h0) else $error("rxd not 00 at carrier");
	dibit_hold_a: assert property (tx_en && cnt != 4'h0 |-> $stable(txd)) else $error("txd moved in slot");
	txen_min_a: assert property ($rose(tx_en) |=> tx_en [*8]) else $error("tx enable too short");
	txen_end_a: assert property ($fell(tx_en) |-> cnt == 4'h0) else $error("tx enable off slot");
	crs_end_a: assert property ($fell(crs_dv) |-> rxd == 2'h0 && !rx_er) else $error("frame end dirty");
	// Main scenarios
	rx_seen_c: cover property ($rose(crs_dv));
	tx_seen_c: cover property ($fell(tx_en));
	col_seen_c: cover property (tx_en && crs_dv);
	err_seen_c: cover property (rx_er);
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
/*
 * Bench joining both ends over the link: user transmit, line receive,
 * error and collision scenarios at 10 Mb/s.
 * Assumes the design package and interface are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic i_mclk, i_rst, ref_clk, carrier, tgl, code_err, tx_valid, tx_last, tx_ready;
	logic tx_stb, ptx_en, rx_valid, rx_err, crs, col, col_seen, crs_seen;
	logic [1:0] rx_dibit, tx_dibit, ptx_dibit, mrx_dibit;
	logic [1:0] txq[$], rxq[$];
	logic erq[$];
	int mismatches, comparisons;
	logic rst_ref_m = 1'b1;
	logic rst_ref = 1'b1;
	rmp_if rmp_if_inst (.ref_clk(ref_clk));
	rmp_phy rmp_phy_inst (.i_mclk(i_mclk), .i_rst(i_rst), .link(rmp_if_inst), .i_speed100(1'b0),
		.i_carrier(carrier), .i_rx_tgl(tgl), .i_rx_dibit(rx_dibit), .i_code_err(code_err),
		.o_tx_en(ptx_en), .o_tx_dibit(ptx_dibit), .o_tx_stb(tx_stb));
	rmp_mac rmp_mac_inst (.i_mclk(i_mclk), .i_rst(i_rst), .link(rmp_if_inst), .i_speed100(1'b0),
		.i_tx_valid(tx_valid), .i_tx_dibit(tx_dibit), .i_tx_last(tx_last), .o_tx_ready(tx_ready),
		.o_rx_valid(rx_valid), .o_rx_dibit(mrx_dibit), .o_rx_err(rx_err), .o_crs(crs), .o_col(col));
	rmp_monitor #(.REP(10)) rmp_monitor_inst (.ref_clk(ref_clk), .i_rst(rst_ref),
		.crs_dv(rmp_if_inst.crs_dv), .rxd(rmp_if_inst.rxd), .rx_er(rmp_if_inst.rx_er),
		.tx_en(rmp_if_inst.tx_en), .txd(rmp_if_inst.txd), .txd_hi(rmp_if_inst.txd_hi),
		.tx_er(rmp_if_inst.tx_er));
	// System clock
	always #50 i_mclk = ~i_mclk;
	// Link clock, phase unrelated
	initial begin
		ref_clk = 1'b0;
		#13;
		forever #40 ref_clk = ~ref_clk;
	end
	// Reset as seen in the link domain, for the checker
	always @(posedge ref_clk) begin
		rst_ref_m <= i_rst;
		rst_ref <= rst_ref_m;
	end
	// Gather di-bits handed to the line, mid-cycle where they are settled
	always @(negedge ref_clk) begin
		if (tx_stb === 1'b1) begin
			txq.push_back(ptx_dibit);
		end
	end
	// Gather delivered di-bits and status, mid-cycle where they are settled
	always @(negedge i_mclk) begin
		if (rx_valid === 1'b1) begin
			rxq.push_back(mrx_dibit);
			erq.push_back(rx_err);
		end
		if (col === 1'b1) begin
			col_seen = 1'b1;
		end
		if (crs === 1'b1) begin
			crs_seen = 1'b1;
		end
	end
	task automatic chk_dibit(input logic [1:0] got, input logic [1:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_count(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_q(input logic [1:0] q[$], input logic [5:0] exp, input int n);
		chk_count(8'(q.size()), 8'(n));
		for (int i = 0; i < n; i++) begin
			chk_dibit(q[i], exp[2*i +: 2]);
		end
	endtask
	task automatic final_report();
		$display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Hand one di-bit to the MAC once it is ready
	task automatic send(input logic [1:0] d, input logic last);
		int n;
		n = 0;
		@(negedge i_mclk);
		while (tx_ready !== 1'b1 && n < 100) begin
			@(negedge i_mclk);
			n++;
		end
		if (n >= 100) begin
			mismatches++;
			$display("CHECK FAILED t=%0t ready timeout got=%h exp=%h", $time, tx_ready, 1'b1);
		end
		tx_valid = 1'b1;
		tx_dibit = d;
		tx_last = last;
		@(negedge i_mclk);
		tx_valid = 1'b0;
		tx_last = 1'b0;
	endtask
	// Line frame, one di-bit per ten link clocks
	task automatic rx_frame(input logic [5:0] ds, input int n, input int err_at);
		@(negedge i_mclk);
		carrier = 1'b1;
		repeat (8) @(negedge i_mclk);
		for (int i = 0; i < n; i++) begin
			if (i == err_at) begin
				code_err = 1'b1;
			end
			rx_dibit = ds[2*i +: 2];
			tgl = ~tgl;
			repeat (8) @(negedge i_mclk);
		end
		carrier = 1'b0;
		code_err = 1'b0;
		repeat (20) @(negedge i_mclk);
	endtask
	// Watchdog
	initial begin
		#200000;
		mismatches++;
		final_report();
	end
	// Test sequence
	initial begin
		{i_mclk, carrier, tgl, code_err, tx_valid, tx_last, col_seen, crs_seen} = 8'h00;
		{rx_dibit, tx_dibit} = 4'h0;
		i_rst = 1'b1;
		mismatches = 0;
		comparisons = 0;
		repeat (16) @(negedge i_mclk);
		i_rst = 1'b0;
		repeat (8) @(negedge i_mclk);
		send(2'h1, 1'b0);
		send(2'h2, 1'b0);
		send(2'h3, 1'b1);
		repeat (20) @(negedge i_mclk);
		chk_q(txq, 6'h39, 3);
		chk_bit(ptx_en, 1'b0);
		chk_dibit(ptx_dibit, 2'h0);
		chk_bit(col_seen, 1'b0);
		txq.delete();
		$display("test transmit done");
		rx_frame(6'h27, 3, 1);
		chk_q(rxq, 6'h27, 3);
		chk_bit(erq[0], 1'b0);
		chk_bit(erq[1], 1'b1);
		chk_bit(erq[2], 1'b1);
		chk_bit(crs_seen, 1'b1);
		chk_bit(crs, 1'b0);
		chk_dibit(rmp_if_inst.rxd, 2'h0);
		rxq.delete();
		erq.delete();
		$display("test receive done");
		fork
			begin
				send(2'h2, 1'b0);
				send(2'h1, 1'b1);
			end
			rx_frame(6'h01, 1, -1);
		join
		chk_bit(col_seen, 1'b1);
		chk_q(txq, 6'h06, 2);
		chk_q(rxq, 6'h01, 1);
		$display("test collision done");
		final_report();
	end
endmodule
`default_nettype wire
